// ===== core/lfg_pkg.sv
// Shared constants for the load function generator
package lfg_pkg;
   // Register offsets (printed values are byte addresses, word index is a quarter of each, all multiples of four)
   localparam logic [7:0] LFG_REG_CTRL   = 8'h00;
   localparam logic [7:0] LFG_REG_STATUS = 8'h04;
   localparam logic [7:0] LFG_REG_FUNC   = 8'h08;
   localparam logic [7:0] LFG_REG_AMPL   = 8'h0c;
   localparam logic [7:0] LFG_REG_OFFS   = 8'h10;
   localparam logic [7:0] LFG_REG_STATIC = 8'h14;
   localparam logic [7:0] LFG_REG_FREQ   = 8'h18;
   localparam logic [7:0] LFG_REG_T1     = 8'h1c;
   localparam logic [7:0] LFG_REG_T2     = 8'h20;
   localparam logic [7:0] LFG_REG_T3     = 8'h24;
   localparam logic [7:0] LFG_REG_T4     = 8'h28;
   localparam logic [7:0] LFG_REG_CYC    = 8'h2c;
   localparam logic [7:0] LFG_REG_PAUSE  = 8'h30;
   localparam logic [7:0] LFG_REG_RAMP0  = 8'h40;
   // Control bits
   localparam int LFG_CTRL_LOAD  = 0;
   localparam int LFG_CTRL_START = 1;
   localparam int LFG_CTRL_STOP  = 2;
   localparam int LFG_CTRL_UNLD  = 3;
   // Function codes
   localparam logic [2:0] LFG_FN_SINE = 3'h0;
   localparam logic [2:0] LFG_FN_TRI  = 3'h1;
   localparam logic [2:0] LFG_FN_RECT = 3'h2;
   localparam logic [2:0] LFG_FN_TRAP = 3'h3;
   localparam logic [2:0] LFG_FN_ENG  = 3'h4;
   // Tick of 0.1 ms, the least segment time
   localparam int TICK_NS  = 100000;
   localparam int CLK_NS   = 10;
   localparam int TICK_CYC = TICK_NS / CLK_NS;
   // Segment time limits in ticks: 0.1 ms to 36000 s
   localparam logic [31:0] T_MIN_TICKS = 32'h0000_0001;
   localparam logic [31:0] T_MAX_TICKS = 32'h1575_2a00;
   localparam logic [15:0] FREQ_MAX_HZ = 16'h2710;
   // Engine-start defaults in millivolts and ticks
   localparam logic [15:0] ENG_V0 = 16'h2ee0;
   localparam logic [15:0] ENG_V1 = 16'h1770;
   localparam logic [15:0] ENG_V2 = 16'h1f40;
   localparam logic [15:0] ENG_V3 = 16'h2710;
   localparam logic [31:0] ENG_T0 = 32'h0000_0032;
   localparam logic [31:0] ENG_T1 = 32'h0000_00c8;
   localparam logic [31:0] ENG_T2 = 32'h0000_0064;
   localparam logic [31:0] ENG_T3 = 32'h0000_2710;
   localparam logic [31:0] ENG_T4 = 32'h0000_03e8;
   // Sequencer states
   typedef enum logic [4:0] {
      LFG_IDLE   = 5'b00001,
      LFG_LOADED = 5'b00010,
      LFG_RUN    = 5'b00100,
      LFG_PAUSE  = 5'b01000,
      LFG_HALT   = 5'b10000
   } lfg_state_e;
endpackage

// ===== core/lfg_core.sv
// Load function generator: register port, sequencer and waveform engine
`timescale 1ns/1ps

module lfg_core
   import lfg_pkg::*;
#(
   parameter int          DW        = 16,
   parameter logic [15:0] NOMINAL   = 16'hffff,
   parameter int          TICK_DIV  = TICK_CYC
)(
   // Clock, reset, enable
   input  wire logic              core_clk,
   input  wire logic              sys_rst,
   input  wire logic              clk_en,
   // Register port
   input  wire logic [7:0]        reg_addr,
   input  wire logic [31:0]       reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [31:0]       reg_rdata,
   // Front panel and alarm pins
   input  wire logic              onoff_btn_pin,
   input  wire logic              alarm_pin,
   // Power stage
   output logic                   input_on,
   output logic      [DW-1:0]     set_value,
   output logic                   target_is_current
);

   ////////////////////////////////////////////////////////////////////
   // Pin synchronisers; second stage is the only reader of the first
   logic [1:0] btn_sync_r, alm_sync_r;
   logic       btn_prev_r;
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         btn_sync_r <= 2'h0;
         alm_sync_r <= 2'h0;
         btn_prev_r <= 1'b0;
      end
      else if (clk_en)
      begin
         btn_sync_r <= {btn_sync_r[0], onoff_btn_pin};
         alm_sync_r <= {alm_sync_r[0], alarm_pin};
         btn_prev_r <= btn_sync_r[1];
      end
   end
   wire btn_press = btn_sync_r[1] & ~btn_prev_r;
   wire alarm     = alm_sync_r[1];

   ////////////////////////////////////////////////////////////////////
   // Configuration registers
   lfg_state_e  state_r;
   logic [2:0]  func_r;
   logic        tgt_cur_r;
   logic [15:0] ampl_r, offs_r, stat_r, freq_r;
   logic [31:0] tim_r [4];
   logic [15:0] cyc_r;
   logic [31:0] pause_r;
   logic [15:0] rv0_r [5];
   logic [15:0] rv1_r [5];
   logic [31:0] rt_r  [5];
   logic        alarm_flag_r, cfg_err_r;
   logic        start_en_r;

   wire cfg_ok  = ~input_on;
   wire wr_ctrl = reg_wr & (reg_addr == LFG_REG_CTRL);
   wire [31:0] tclamp = (reg_wdata < T_MIN_TICKS) ? T_MIN_TICKS :
                        (reg_wdata > T_MAX_TICKS) ? T_MAX_TICKS : reg_wdata;

   // Writes honoured only while input off; refused writes raise cfg error
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         func_r    <= LFG_FN_SINE;
         tgt_cur_r <= 1'b0;
         ampl_r    <= 16'h0000;
         offs_r    <= 16'h0000;
         stat_r    <= 16'h0000;
         freq_r    <= 16'h0001;
         cyc_r     <= 16'h0001;
         pause_r   <= T_MIN_TICKS;
         cfg_err_r <= 1'b0;
         for (int i = 0; i < 4; i++)
            tim_r[i] <= T_MIN_TICKS;
         // Default engine-start ramps
         rv0_r[0] <= ENG_V0; rv1_r[0] <= ENG_V1; rt_r[0] <= ENG_T0;
         rv0_r[1] <= ENG_V1; rv1_r[1] <= ENG_V1; rt_r[1] <= ENG_T1;
         rv0_r[2] <= ENG_V1; rv1_r[2] <= ENG_V2; rt_r[2] <= ENG_T2;
         rv0_r[3] <= ENG_V2; rv1_r[3] <= ENG_V2; rt_r[3] <= ENG_T3;
         rv0_r[4] <= ENG_V2; rv1_r[4] <= ENG_V3; rt_r[4] <= ENG_T4;
      end
      else if (clk_en && reg_wr && reg_addr != LFG_REG_CTRL)
      begin
         if (!cfg_ok)
            cfg_err_r <= 1'b1;
         else
         begin
            case (reg_addr)
               LFG_REG_FUNC:
               begin
                  // Engine-start refused on current target
                  if (reg_wdata[2:0] == LFG_FN_ENG && reg_wdata[8])
                     cfg_err_r <= 1'b1;
                  else
                  begin
                     func_r    <= reg_wdata[2:0];
                     tgt_cur_r <= reg_wdata[8];
                  end
               end
               // Level checks: A <= nominal - offs for every function; sine also needs offs >= A
               LFG_REG_AMPL:
                  if (reg_wdata[15:0] > NOMINAL - offs_r ||
                      (func_r == LFG_FN_SINE && reg_wdata[15:0] > offs_r))
                     cfg_err_r <= 1'b1;
                  else ampl_r <= reg_wdata[15:0];
               LFG_REG_OFFS:
                  if (reg_wdata[15:0] > NOMINAL - ampl_r ||
                      (func_r == LFG_FN_SINE && reg_wdata[15:0] < ampl_r))
                     cfg_err_r <= 1'b1;
                  else offs_r <= reg_wdata[15:0];
               LFG_REG_STATIC: stat_r <= reg_wdata[15:0];
               LFG_REG_FREQ:
                  if (reg_wdata[15:0] == 16'h0000 || reg_wdata[15:0] > FREQ_MAX_HZ)
                     cfg_err_r <= 1'b1;
                  else freq_r <= reg_wdata[15:0];
               LFG_REG_T1: tim_r[0] <= tclamp;
               LFG_REG_T2: tim_r[1] <= tclamp;
               LFG_REG_T3: tim_r[2] <= tclamp;
               LFG_REG_T4: tim_r[3] <= tclamp;
               LFG_REG_CYC: cyc_r <= reg_wdata[15:0];
               LFG_REG_PAUSE: pause_r <= tclamp;
               default:
               begin
                  // Ramp block: base + 0x0c per ramp (start, end, time)
                  for (int i = 0; i < 5; i++)
                  begin
                     if (reg_addr == LFG_REG_RAMP0 + 8'(12*i))
                        rv0_r[i] <= reg_wdata[15:0];
                     if (reg_addr == LFG_REG_RAMP0 + 8'(12*i + 4))
                        rv1_r[i] <= reg_wdata[15:0];
                     if (reg_addr == LFG_REG_RAMP0 + 8'(12*i + 8))
                        rt_r[i] <= tclamp;
                  end
               end
            endcase
         end
      end
      else if (clk_en && reg_rd && reg_addr == LFG_REG_STATUS)
         cfg_err_r <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////
   // Tick generator
   logic [31:0] tdiv_r;
   wire tick = (tdiv_r == 32'(TICK_DIV - 1));
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         tdiv_r <= 32'h0;
      else if (clk_en)
         tdiv_r <= tick ? 32'h0 : tdiv_r + 32'h1;
   end

   ////////////////////////////////////////////////////////////////////
   // Sequencer
   logic [2:0]  seg_r;
   logic [31:0] tcnt_r;
   logic [15:0] cdone_r;
   logic [31:0] phase_r;
   wire start_cmd = wr_ctrl & reg_wdata[LFG_CTRL_START];
   wire stop_cmd  = wr_ctrl & reg_wdata[LFG_CTRL_STOP];
   wire running   = (state_r == LFG_RUN) || (state_r == LFG_PAUSE);
   wire [31:0] seg_len = (func_r == LFG_FN_ENG) ? rt_r[seg_r] : tim_r[seg_r[1:0]];
   wire [2:0]  seg_last = (func_r == LFG_FN_ENG)  ? 3'h4 :
                          (func_r == LFG_FN_TRAP) ? 3'h3 : 3'h1;
   // Pause runs on its own timer, not on the first ramp's time
   wire [31:0] cur_len = (state_r == LFG_PAUSE) ? pause_r : seg_len;
   wire seg_end = tick && (tcnt_r + 32'h1 >= cur_len);

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         state_r      <= LFG_IDLE;
         input_on     <= 1'b0;
         start_en_r   <= 1'b0;
         alarm_flag_r <= 1'b0;
         seg_r        <= 3'h0;
         tcnt_r       <= 32'h0;
         cdone_r      <= 16'h0;
      end
      else if (clk_en)
      begin
         if (alarm)
         begin
            // Alarm wins over all commands
            state_r      <= LFG_IDLE;
            input_on     <= 1'b0;
            start_en_r   <= 1'b0;
            alarm_flag_r <= 1'b1;
         end
         else
         begin
            if (reg_rd && reg_addr == LFG_REG_STATUS)
               alarm_flag_r <= 1'b0;
            case (state_r)
               LFG_IDLE:
                  if (wr_ctrl && reg_wdata[LFG_CTRL_LOAD])
                  begin
                     // Static values on; input on and start enabled in the same cycle
                     input_on   <= 1'b1;
                     start_en_r <= 1'b1;
                     state_r    <= LFG_LOADED;
                  end
               LFG_LOADED, LFG_HALT:
                  if (start_en_r && (start_cmd || (btn_press && !input_on)))
                  begin
                     input_on <= 1'b1;
                     state_r  <= LFG_RUN;
                     seg_r    <= 3'h0;
                     tcnt_r   <= 32'h0;
                     cdone_r  <= 16'h0;
                  end
                  else if (btn_press)
                     input_on <= 1'b0;
                  else if (wr_ctrl && reg_wdata[LFG_CTRL_UNLD] && !input_on)
                  begin
                     start_en_r <= 1'b0;
                     state_r    <= LFG_IDLE;
                  end
               LFG_RUN, LFG_PAUSE:
                  if (btn_press)
                  begin
                     input_on <= 1'b0;
                     state_r  <= LFG_HALT;
                  end
                  else if (stop_cmd)
                     state_r <= LFG_HALT;
                  else if (seg_end && state_r == LFG_PAUSE)
                  begin
                     state_r <= LFG_RUN;
                     tcnt_r  <= 32'h0;
                  end
                  else if (seg_end && seg_r == seg_last)
                  begin
                     seg_r  <= 3'h0;
                     tcnt_r <= 32'h0;
                     if (func_r == LFG_FN_ENG)
                     begin
                        cdone_r <= cdone_r + 16'h1;
                        // Zero cycles means endless
                        if (cyc_r != 16'h0 && cdone_r + 16'h1 >= cyc_r)
                           state_r <= LFG_HALT;
                        else if (cyc_r != 16'h1)
                           state_r <= LFG_PAUSE;
                     end
                  end
                  else if (seg_end)
                  begin
                     seg_r  <= seg_r + 3'h1;
                     tcnt_r <= 32'h0;
                  end
                  else if (tick)
                     tcnt_r <= tcnt_r + 32'h1;
               default: state_r <= LFG_IDLE;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Waveform sample; pause counts against pause time
   logic [15:0] frac;  // position within segment, 0..ffff
   always_comb
   begin
      frac = 16'((64'(tcnt_r) << 16) / 64'(cur_len));
   end
   function automatic logic [15:0] lerp(input logic [15:0] a, input logic [15:0] b,
                                        input logic [15:0] f);
      logic signed [33:0] d;
      d = 34'(signed'({1'b0, b})) - 34'(signed'({1'b0, a}));
      lerp = 16'(34'(signed'({1'b0, a})) + ((d * 34'(signed'({1'b0, f}))) >>> 16));
   endfunction

   // Half-wave sine approximation by parabola
   logic [15:0] sin_u;
   always_comb
   begin
      logic [15:0] p;
      logic [31:0] q;
      p = phase_r[31] ? ~phase_r[30:15] : phase_r[30:15];
      q = 32'(p) * 32'(16'hffff - p);
      sin_u = q[29:14];
   end

   // Phase accumulator advances per tick by freq / ticks-per-second
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         phase_r <= 32'h0;
      else if (clk_en)
      begin
         if (state_r != LFG_RUN)
            phase_r <= 32'h0;
         else if (tick)
            phase_r <= phase_r + 32'((64'(freq_r) << 32) / 64'd10000);
      end
   end

   // Output sample, updated on ticks while running, on every enabled clock otherwise
   logic [15:0] base_lvl, top_lvl;
   assign base_lvl = offs_r;
   assign top_lvl  = offs_r + ampl_r;
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         set_value <= '0;
      else if (clk_en && (tick || state_r != LFG_RUN))
      begin
         if (state_r != LFG_RUN)
            // Static level; current has none, so zero
            set_value <= tgt_cur_r ? '0 : DW'(stat_r);
         else
            case (func_r)
               LFG_FN_SINE:
                  set_value <= DW'(phase_r[31] ? offs_r - lerp(16'h0, ampl_r, sin_u)
                                               : offs_r + lerp(16'h0, ampl_r, sin_u));
               LFG_FN_TRI:
                  set_value <= DW'(seg_r[0] ? lerp(top_lvl, base_lvl, frac)
                                            : lerp(base_lvl, top_lvl, frac));
               LFG_FN_RECT:
                  set_value <= DW'(seg_r[0] ? base_lvl : top_lvl);
               LFG_FN_TRAP:
                  case (seg_r[1:0])
                     2'h0: set_value <= DW'(lerp(base_lvl, top_lvl, frac));
                     2'h1: set_value <= DW'(top_lvl);
                     2'h2: set_value <= DW'(lerp(top_lvl, base_lvl, frac));
                     default: set_value <= DW'(base_lvl);
                  endcase
               LFG_FN_ENG:
                  set_value <= DW'(lerp(rv0_r[seg_r], rv1_r[seg_r], frac));
               default: set_value <= DW'(stat_r);
            endcase
      end
   end
   assign target_is_current = tgt_cur_r;

   ////////////////////////////////////////////////////////////////////
   // Read port, data one cycle after the strobe
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         reg_rdata <= 32'h0;
      else if (clk_en)
      begin
         reg_rdata <= 32'h0;
         if (reg_rd)
            case (reg_addr)
               LFG_REG_STATUS: reg_rdata <= {24'h0, state_r, alarm_flag_r, cfg_err_r,
                                             input_on};
               LFG_REG_FUNC:   reg_rdata <= {23'h0, tgt_cur_r, 5'h0, func_r};
               LFG_REG_AMPL:   reg_rdata <= {16'h0, ampl_r};
               LFG_REG_OFFS:   reg_rdata <= {16'h0, offs_r};
               LFG_REG_STATIC: reg_rdata <= {16'h0, stat_r};
               LFG_REG_FREQ:   reg_rdata <= {16'h0, freq_r};
               LFG_REG_CYC:    reg_rdata <= {16'h0, cyc_r};
               default:        reg_rdata <= 32'h0;
            endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Assertions
   chk_run_needs_load: assert property (@(posedge core_clk) disable iff (sys_rst)
      $rose(state_r == LFG_RUN) |-> $past(start_en_r))
      else $error("generation began without load");
   chk_run_input_on: assert property (@(posedge core_clk) disable iff (sys_rst)
      state_r == LFG_RUN |-> input_on)
      else $error("running with input off");
   chk_alarm_abort: assert property (@(posedge core_clk) disable iff (sys_rst)
      clk_en && alarm |=> !input_on && alarm_flag_r && state_r == LFG_IDLE)
      else $error("alarm did not abort");
   chk_stop_keeps_on: assert property (@(posedge core_clk) disable iff (sys_rst)
      clk_en && !alarm && !btn_press && stop_cmd && state_r == LFG_RUN
      |=> state_r == LFG_HALT && input_on)
      else $error("stop switched input off");
   chk_btn_off: assert property (@(posedge core_clk) disable iff (sys_rst)
      clk_en && !alarm && btn_press && state_r == LFG_RUN |=> !input_on)
      else $error("button did not switch off");
   chk_cfg_locked: assert property (@(posedge core_clk) disable iff (sys_rst)
      input_on && clk_en && reg_wr && reg_addr == LFG_REG_AMPL |=> $stable(ampl_r))
      else $error("config changed while on");
   chk_eng_volt_only: assert property (@(posedge core_clk) disable iff (sys_rst)
      !(func_r == LFG_FN_ENG && tgt_cur_r))
      else $error("engine curve on current");
   chk_static_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
      clk_en && state_r == LFG_HALT && !tgt_cur_r |=> set_value == DW'($past(stat_r)))
      else $error("static value not restored");
   chk_cur_zero: assert property (@(posedge core_clk) disable iff (sys_rst)
      clk_en && state_r == LFG_LOADED && tgt_cur_r |=> set_value == '0)
      else $error("current not from zero");
   chk_freq_limit: assert property (@(posedge core_clk) disable iff (sys_rst)
      freq_r <= FREQ_MAX_HZ)
      else $error("frequency above limit");
   cov_run:   cover property (@(posedge core_clk) state_r == LFG_RUN);
   cov_pause: cover property (@(posedge core_clk) state_r == LFG_PAUSE);
   cov_alarm: cover property (@(posedge core_clk) running && alarm);
   cov_eng_halt: cover property (@(posedge core_clk) func_r == LFG_FN_ENG && state_r == LFG_HALT);

endmodule // lfg_core

// ===== test/lfg_panel.sv
// Front panel button and alarm source model for the function generator
`timescale 1ns/1ps
module lfg_panel (
   // Clock
   input  wire logic core_clk,
   // Bench requests
   input  wire logic press_req,
   input  wire logic trip_req,
   // Pins toward the device
   output logic      onoff_btn_pin,
   output logic      alarm_pin
);
   logic [2:0] hold_r = 3'h0;
   logic       trip_r = 1'b0;
   // Press held six clocks so the synchroniser surely sees it
   always_ff @(posedge core_clk)
   begin
      if (press_req)
         hold_r <= 3'h6;
      else if (hold_r != 3'h0)
         hold_r <= hold_r - 3'h1;
   end
   // Protection trip follows the request level
   always_ff @(posedge core_clk)
   begin
      trip_r <= trip_req;
   end
   assign onoff_btn_pin = (hold_r != 3'h0);
   assign alarm_pin     = trip_r;
endmodule // lfg_panel

// ===== test/load_function_generator_bench.sv
// Self-checking bench for the load function generator
`timescale 1ns/1ps
module load_function_generator_bench
   import lfg_pkg::*;
   ;
   logic        core_clk  = 1'b0;
   logic        sys_rst   = 1'b1;
   logic        clk_en    = 1'b1;
   logic [7:0]  reg_addr  = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic        reg_wr    = 1'b0;
   logic        reg_rd    = 1'b0;
   logic        press_req = 1'b0;
   logic        trip_req  = 1'b0;
   logic [31:0] reg_rdata;
   logic [31:0] rd_d;
   logic [15:0] set_value;
   logic        onoff_btn_pin;
   logic        alarm_pin;
   logic        input_on;
   logic        target_is_current;
   logic        hi_seen;
   logic        lo_seen;
   logic        mid_seen;
   int          err_count   = 0;
   int          check_count = 0;
   int          cyc         = 0;
   ////////////////////////////////////////////////////////////////////////////////
   // Short tick keeps waveform segments a few clocks long
   lfg_core #(.TICK_DIV(4)) dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .onoff_btn_pin(onoff_btn_pin), .alarm_pin(alarm_pin),
      .input_on(input_on), .set_value(set_value), .target_is_current(target_is_current));
   lfg_panel panel_u (.core_clk(core_clk), .press_req(press_req), .trip_req(trip_req),
      .onoff_btn_pin(onoff_btn_pin), .alarm_pin(alarm_pin));
   // Clock and hang guard
   always #5 core_clk = ~core_clk;
   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         err_count++;
         end_sim();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic end_sim();
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp)
      begin
         err_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 rd_d = reg_rdata;
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic press();
      @(posedge core_clk);
      press_req <= 1'b1;
      @(posedge core_clk);
      press_req <= 1'b0;
      idle(12);
   endtask
   // Records which of three levels the set value shows over n clocks
   task automatic watch(input int n, input logic [15:0] hv, lv, mv);
      hi_seen = 1'b0;
      lo_seen = 1'b0;
      mid_seen = 1'b0;
      repeat (n)
      begin
         idle(1);
         hi_seen |= (set_value === hv);
         lo_seen |= (set_value === lv);
         mid_seen |= (set_value === mv);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      repeat (8) @(posedge core_clk);
      sys_rst <= 1'b0;
      rd(LFG_REG_STATUS);
      chk("status", 32'h08, rd_d);
      wr(LFG_REG_CTRL, 32'h2);
      idle(2);
      chk("input_on", 32'h0, 32'(input_on));
      wr(LFG_REG_FUNC, 32'h2);
      wr(LFG_REG_AMPL, 32'h100);
      wr(LFG_REG_OFFS, 32'h200);
      wr(LFG_REG_STATIC, 32'h50);
      wr(LFG_REG_T1, 32'h1);
      wr(LFG_REG_T2, 32'h1);
      rd(LFG_REG_FUNC);
      chk("func", 32'h2, rd_d);
      wr(LFG_REG_CTRL, 32'h1);
      idle(2);
      chk("input_on", 32'h1, 32'(input_on));
      chk("set_value", 32'h50, 32'(set_value));
      wr(LFG_REG_AMPL, 32'h7);
      rd(LFG_REG_STATUS);
      chk("status", 32'h13, rd_d);
      rd(LFG_REG_AMPL);
      chk("ampl", 32'h100, rd_d);
      wr(LFG_REG_CTRL, 32'h2);
      // Both levels must show within six one-tick segments
      watch(24, 16'h300, 16'h200, 16'h300);
      chk("rect levels", 32'h3, {30'h0, hi_seen, lo_seen});
      wr(LFG_REG_CTRL, 32'h4);
      idle(2);
      chk("input_on", 32'h1, 32'(input_on));
      chk("set_value", 32'h50, 32'(set_value));
      wr(LFG_REG_CTRL, 32'h2);
      press();
      chk("input_on", 32'h0, 32'(input_on));
      rd(LFG_REG_STATUS);
      chk("status", 32'h80, rd_d);
      press();
      chk("input_on", 32'h1, 32'(input_on));
      trip_req <= 1'b1;
      idle(4);
      chk("input_on", 32'h0, 32'(input_on));
      rd(LFG_REG_STATUS);
      chk("status", 32'h0c, rd_d);
      trip_req <= 1'b0;
      idle(3);
      rd(LFG_REG_STATUS);
      chk("status", 32'h0c, rd_d);
      wr(LFG_REG_FREQ, 32'h2710);
      wr(LFG_REG_FREQ, 32'h2711);
      rd(LFG_REG_FREQ);
      chk("freq", 32'h2710, rd_d);
      wr(LFG_REG_FUNC, 32'h0);
      wr(LFG_REG_OFFS, 32'h80);
      rd(LFG_REG_OFFS);
      chk("offs", 32'h200, rd_d);
      rd(LFG_REG_STATUS);
      chk("status", 32'h0a, rd_d);
      wr(LFG_REG_FUNC, 32'h104);
      rd(LFG_REG_STATUS);
      chk("status", 32'h0a, rd_d);
      wr(LFG_REG_FUNC, 32'h102);
      wr(LFG_REG_CTRL, 32'h1);
      idle(2);
      chk("set_value", 32'h0, 32'(set_value));
      chk("target", 32'h1, 32'(target_is_current));
      rd(8'h3c);
      chk("unmapped", 32'h0, rd_d);
      // Frozen clock enable: a start write must be lost
      @(posedge core_clk);
      clk_en <= 1'b0;
      wr(LFG_REG_CTRL, 32'h2);
      clk_en <= 1'b1;
      rd(LFG_REG_STATUS);
      chk("status", 32'h11, rd_d);
      // Button turns the loaded input off, then unload returns to idle
      press();
      wr(LFG_REG_CTRL, 32'h8);
      rd(LFG_REG_STATUS);
      chk("status", 32'h08, rd_d);
      // Two-tick slopes put the slope midpoint on a sample
      wr(LFG_REG_FUNC, 32'h3);
      wr(LFG_REG_T1, 32'h2);
      wr(LFG_REG_T3, 32'h2);
      wr(LFG_REG_T4, 32'h1);
      wr(LFG_REG_CTRL, 32'h1);
      wr(LFG_REG_CTRL, 32'h2);
      watch(48, 16'h300, 16'h200, 16'h280);
      chk("trap levels", 32'h7, {29'h0, hi_seen, lo_seen, mid_seen});
      // Engine curve: default voltages, one-tick ramps, two cycles, long pause
      wr(LFG_REG_CTRL, 32'h4);
      press();
      wr(LFG_REG_FUNC, 32'h4);
      wr(LFG_REG_CYC, 32'h2);
      wr(LFG_REG_PAUSE, 32'h14);
      for (int i = 0; i < 5; i++)
         wr(LFG_REG_RAMP0 + 8'(12*i + 8), 32'h1);
      wr(LFG_REG_CTRL, 32'h2);
      watch(8, ENG_V0, ENG_V1, ENG_V1);
      chk("ramp defaults", 32'h3, {30'h0, hi_seen, lo_seen});
      idle(40);
      rd(LFG_REG_STATUS);
      chk("status", 32'h41, rd_d);
      idle(80);
      rd(LFG_REG_STATUS);
      chk("status", 32'h81, rd_d);
      end_sim();
   end
endmodule // load_function_generator_bench
